// *** rtl/btw_timer.sv ***
// Top of the buffered 16-bit timer with three waveform channels
`timescale 1ns/10ps
`default_nettype none

module btw_timer #(
  parameter int N_CH = 3
) (
  input  wire logic             I_MCLK,
  input  wire logic             I_SYS_RST,
  input  wire logic             I_RUN_ENABLE,
  input  wire logic [2:0]       I_PRESCALE_CHOICE,
  input  wire logic             I_COUNT_DOWN,
  input  wire logic             I_EVENT_COUNT_ON,
  input  wire logic             I_EVENT_IN,
  input  wire logic [1:0]       I_WAVEFORM_KIND,
  input  wire logic [N_CH-1:0]  I_MATCH_OUTPUT_ON,
  input  wire logic [N_CH-1:0]  I_PIN_OUT,
  input  wire logic             I_COUNT_WR,
  input  wire logic [15:0]      I_COUNT_WDATA,
  input  wire logic             I_TOP_WR,
  input  wire logic [15:0]      I_TOP_WDATA,
  input  wire logic             I_TOP_SHADOW_WR,
  input  wire logic [15:0]      I_TOP_SHADOW_WDATA,
  input  wire logic [N_CH-1:0]  I_MATCH_WR,
  input  wire logic [15:0]      I_MATCH_WDATA,
  input  wire logic [N_CH-1:0]  I_MATCH_SHADOW_WR,
  input  wire logic [15:0]      I_MATCH_SHADOW_WDATA,
  input  wire logic [N_CH-1:0]  I_MATCH_FLAG_CLR,
  output logic [15:0]           O_COUNT_VALUE,
  output logic [15:0]           O_TOP_VALUE,
  output logic                  O_TOP_SHADOW_VALID,
  output logic [N_CH-1:0]       O_MATCH_SHADOW_VALID,
  output logic [N_CH-1:0]       O_MATCH_FLAG,
  output logic                  O_UPDATE,
  output logic                  O_DUAL_DOWN,
  output logic [N_CH-1:0]       O_WAVE_SIGNAL,
  output logic [N_CH-1:0]       O_WAVE_PIN_OUT
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [15:0]          cnt_q;
  logic [15:0]          cnt_d;
  logic [15:0]          top_q;
  logic [15:0]          top_sh_q;
  logic                 top_sv_q;
  logic [15:0]          mat_q   [N_CH];
  logic [15:0]          mat_sh_q [N_CH];
  logic [N_CH-1:0]      mat_sv_q;
  logic [N_CH-1:0]      flag_q;
  logic [N_CH-1:0]      wave_q;
  logic [N_CH-1:0]      pin_q;
  logic                 upd_q;
  btw_pkg::btw_dir_t    dir_q;
  btw_pkg::btw_dir_t    dir_d;
  btw_pkg::btw_kind_t   kind;
  logic                 ps_tick;
  logic                 tick;
  logic                 adv;
  logic                 dual;
  logic                 down;
  logic [15:0]          top_eff;
  logic                 at_top;
  logic                 at_bot;
  logic                 upd;
  logic [N_CH-1:0]      eq;
  logic                 wave_mode;

  assign kind = btw_pkg::btw_kind_t'(I_WAVEFORM_KIND);
  assign dual = (kind == btw_pkg::KIND_DUAL);

  // ------------------------------------------------------------------
  // Tick source
  // ------------------------------------------------------------------
  btw_prescaler u_prescaler (
    .i_clk    (I_MCLK),
    .i_rst    (I_SYS_RST),
    .i_run    (I_RUN_ENABLE),
    .i_choice (I_PRESCALE_CHOICE),
    .o_tick   (ps_tick)
  );

  // Events replace prescaled ticks; run enable still gates both
  assign tick = I_RUN_ENABLE &&
                (I_EVENT_COUNT_ON ? I_EVENT_IN : ps_tick);

  // A count write suppresses the tick's own count step
  assign adv = tick && !I_COUNT_WR;

  // ------------------------------------------------------------------
  // Sequence decode
  // ------------------------------------------------------------------
  // Frequency mode takes its period from channel 0's match value
  assign top_eff = (kind == btw_pkg::KIND_FREQ) ? mat_q[0] : top_q;

  assign down   = dual ? (dir_q == btw_pkg::DIR_DOWN) : I_COUNT_DOWN;
  assign at_bot = (cnt_q == btw_pkg::CNT_ZERO);
  // Equality only: a top below the count is passed by and met
  // again after wrapping through the all-ones value
  assign at_top = (cnt_q == top_eff);

  // Dual slope updates at bottom; others at the end of their sweep
  assign upd = adv && (dual ? (down && at_bot)
                            : (down ? at_bot : at_top));

  always_comb begin
    for (int n = 0; n < N_CH; n++) begin
      eq[n] = (cnt_q == mat_q[n]);
    end
  end

  assign wave_mode = (kind != btw_pkg::KIND_NORMAL);

  // ------------------------------------------------------------------
  // Counter next value
  // ------------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (!dual) begin
      dir_d = btw_pkg::DIR_UP;
    end
    if (I_COUNT_WR) begin
      cnt_d = I_COUNT_WDATA;
    end else if (tick) begin
      if (dual) begin
        if (!down) begin
          if (at_top && at_bot) begin
            cnt_d = btw_pkg::CNT_ZERO;
          end else if (at_top) begin
            cnt_d = cnt_q - btw_pkg::CNT_ONE;
            dir_d = btw_pkg::DIR_DOWN;
          end else begin
            cnt_d = cnt_q + btw_pkg::CNT_ONE;
          end
        end else begin
          if (at_bot) begin
            cnt_d = btw_pkg::CNT_ONE;
            dir_d = btw_pkg::DIR_UP;
          end else begin
            cnt_d = cnt_q - btw_pkg::CNT_ONE;
          end
        end
      end else if (down) begin
        if (at_bot) begin
          cnt_d = top_eff;
        end else begin
          cnt_d = cnt_q - btw_pkg::CNT_ONE;
        end
      end else begin
        if (at_top) begin
          cnt_d = btw_pkg::CNT_ZERO;
        end else begin
          // All ones plus one wraps to zero by width
          cnt_d = cnt_q + btw_pkg::CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cnt_q <= btw_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      dir_q <= btw_pkg::DIR_UP;
    end else begin
      dir_q <= dir_d;
    end
  end

  // ------------------------------------------------------------------
  // Top value and its shadow
  // ------------------------------------------------------------------
  // Direct write beats a same-cycle shadow copy
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      top_q <= btw_pkg::TOP_RESET;
    end else if (I_TOP_WR) begin
      top_q <= I_TOP_WDATA;
    end else if (upd && top_sv_q) begin
      top_q <= top_sh_q;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      top_sh_q <= btw_pkg::TOP_RESET;
    end else if (I_TOP_SHADOW_WR) begin
      top_sh_q <= I_TOP_SHADOW_WDATA;
    end
  end

  // A write landing with the update keeps the flag set
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      top_sv_q <= 1'b0;
    end else if (I_TOP_SHADOW_WR) begin
      top_sv_q <= 1'b1;
    end else if (upd) begin
      top_sv_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Match values and their shadows
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int n = 0; n < N_CH; n++) begin
        mat_q[n] <= btw_pkg::MATCH_RESET;
      end
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (I_MATCH_WR[n]) begin
          mat_q[n] <= I_MATCH_WDATA;
        end else if (upd && mat_sv_q[n]) begin
          mat_q[n] <= mat_sh_q[n];
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int n = 0; n < N_CH; n++) begin
        mat_sh_q[n] <= btw_pkg::MATCH_RESET;
      end
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (I_MATCH_SHADOW_WR[n]) begin
          mat_sh_q[n] <= I_MATCH_SHADOW_WDATA;
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mat_sv_q <= '0;
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (I_MATCH_SHADOW_WR[n]) begin
          mat_sv_q[n] <= 1'b1;
        end else if (upd) begin
          mat_sv_q[n] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Match flags
  // ------------------------------------------------------------------
  // A match is flagged on the tick that moves the counter off it;
  // a new match beats a same-cycle clear
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      flag_q <= '0;
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (tick && eq[n]) begin
          flag_q[n] <= 1'b1;
        end else if (I_MATCH_FLAG_CLR[n]) begin
          flag_q[n] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= upd;
    end
  end

  // ------------------------------------------------------------------
  // Waveform generator
  // ------------------------------------------------------------------
  // Stopped or normal mode parks every wave signal low
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wave_q <= '0;
    end else if (!I_RUN_ENABLE || !wave_mode) begin
      wave_q <= '0;
    end else if (adv) begin
      for (int n = 0; n < N_CH; n++) begin
        case (kind)
          btw_pkg::KIND_FREQ: begin
            if (eq[n]) begin
              wave_q[n] <= !wave_q[n];
            end
          end
          btw_pkg::KIND_SINGLE: begin
            if (!down && at_top) begin
              wave_q[n] <= 1'b1;
            end else if (eq[n]) begin
              wave_q[n] <= 1'b0;
            end
          end
          btw_pkg::KIND_DUAL: begin
            if (down && at_bot) begin
              wave_q[n] <= 1'b1;
            end else if (eq[n]) begin
              wave_q[n] <= down;
            end
          end
          default: begin
            wave_q[n] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin override
  // ------------------------------------------------------------------
  // Registered so the pin never sees a decode glitch, at one cycle
  // of latency after the wave signal
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_q <= '0;
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (wave_mode && !I_EVENT_COUNT_ON && I_MATCH_OUTPUT_ON[n]) begin
          pin_q[n] <= wave_q[n];
        end else begin
          pin_q[n] <= I_PIN_OUT[n];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign O_COUNT_VALUE        = cnt_q;
  assign O_TOP_VALUE          = top_q;
  assign O_TOP_SHADOW_VALID   = top_sv_q;
  assign O_MATCH_SHADOW_VALID = mat_sv_q;
  assign O_MATCH_FLAG         = flag_q;
  assign O_UPDATE             = upd_q;
  assign O_DUAL_DOWN          = (dir_q == btw_pkg::DIR_DOWN);
  assign O_WAVE_SIGNAL        = wave_q;
  assign O_WAVE_PIN_OUT       = pin_q;

endmodule : btw_timer

`default_nettype wire

// *** rtl/btw_pkg.sv ***
// Constants and types shared by the buffered timer waveform core
//
// Summary of operation
// - Zero count is the bottom of sequence
// - All-ones count is the maximum
// - Update at bottom or top, per mode
// - Count prescaled clock ticks, up or down
// - Upward at top, clear on next tick
// - Downward at zero, reload the top value
// - Count write is immediate and wins
// - Direction change accepted while counting
// - Event-count-on advances counter on events
// - Shadow write sets valid; update copies, clears
// - Active and shadow match both writable
// - Direct top write takes effect at once
// - Top below count wraps through full range
// - Buffered top moves only on update
// - Match sets channel flag next tick
// - Match shadows load only on update
// - Pin override needs mode, clock ticks, enable
// - Frequency mode toggles on every match
// - Single slope: set at top when counting up, clear match
// - Top supports two to sixteen bits
// - Dual slope set bottom, match clears/sets
`default_nettype none

package btw_pkg;

  localparam int          CNT_W       = 16;
  localparam int          N_CH        = 3;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] TOP_RESET   = 16'hFFFF;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [15:0] TOP_MIN_PWM = 16'h0003;
  localparam int          PS_W        = 10;
  localparam int          SEL_W       = 3;

  typedef enum logic [1:0] {
    KIND_NORMAL = 2'h0,
    KIND_FREQ   = 2'h1,
    KIND_SINGLE = 2'h3,
    KIND_DUAL   = 2'h2
  } btw_kind_t;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } btw_dir_t;

  // Divider minus one for each prescale choice
  function automatic logic [9:0] btw_ps_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    btw_ps_limit = 10'h000;
      3'h1:    btw_ps_limit = 10'h001;
      3'h2:    btw_ps_limit = 10'h003;
      3'h3:    btw_ps_limit = 10'h007;
      3'h4:    btw_ps_limit = 10'h00F;
      3'h5:    btw_ps_limit = 10'h03F;
      3'h6:    btw_ps_limit = 10'h0FF;
      default: btw_ps_limit = 10'h3FF;
    endcase
  endfunction : btw_ps_limit

endpackage : btw_pkg

`default_nettype wire

// *** rtl/btw_prescaler.sv ***
// Clock prescaler producing single-cycle timer ticks
`timescale 1ns/10ps
`default_nettype none

module btw_prescaler (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [2:0] i_choice,
  output logic            o_tick
);

  logic [9:0] div_q;
  logic [9:0] lim;

  assign lim    = btw_pkg::btw_ps_limit(i_choice);
  assign o_tick = i_run && (div_q >= lim);

  // Held at zero while stopped so the first period is full length
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 10'h000;
    end else if (!i_run || o_tick) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

endmodule : btw_prescaler

`default_nettype wire

// *** tb/btw_timer_properties.sv ***
// Port-level checks for the buffered timer waveform core
`timescale 1ns/10ps
`default_nettype none

module btw_timer_properties #(
  parameter int N_CH = 3
) (
  input wire logic            I_MCLK,
  input wire logic            I_SYS_RST,
  input wire logic            I_RUN_ENABLE,
  input wire logic [2:0]      I_PRESCALE_CHOICE,
  input wire logic            I_COUNT_DOWN,
  input wire logic            I_EVENT_COUNT_ON,
  input wire logic            I_EVENT_IN,
  input wire logic [1:0]      I_WAVEFORM_KIND,
  input wire logic [N_CH-1:0] I_MATCH_OUTPUT_ON,
  input wire logic [N_CH-1:0] I_PIN_OUT,
  input wire logic            I_COUNT_WR,
  input wire logic [15:0]     I_COUNT_WDATA,
  input wire logic            I_TOP_WR,
  input wire logic            I_TOP_SHADOW_WR,
  input wire logic [15:0]     O_COUNT_VALUE,
  input wire logic [15:0]     O_TOP_VALUE,
  input wire logic            O_TOP_SHADOW_VALID,
  input wire logic            O_UPDATE,
  input wire logic [N_CH-1:0] O_WAVE_SIGNAL,
  input wire logic [N_CH-1:0] O_WAVE_PIN_OUT
);
  // ----------------------------------------
  // Helper terms
  // ----------------------------------------
  logic            fast_run;
  logic            plain_kind;
  logic [N_CH-1:0] ovr_mask;
  logic [N_CH-1:0] pin_exp;
  // Undivided clock means a tick on every edge, so steps are predictable
  assign fast_run   = I_RUN_ENABLE && !I_EVENT_COUNT_ON && !I_COUNT_WR
                      && I_PRESCALE_CHOICE == 3'h0;
  assign plain_kind = I_WAVEFORM_KIND == btw_pkg::KIND_NORMAL
                      || I_WAVEFORM_KIND == btw_pkg::KIND_SINGLE;
  assign ovr_mask   = {N_CH{I_WAVEFORM_KIND != btw_pkg::KIND_NORMAL
                      && !I_EVENT_COUNT_ON}} & I_MATCH_OUTPUT_ON;
  assign pin_exp    = (ovr_mask & O_WAVE_SIGNAL) | (~ovr_mask & I_PIN_OUT);

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);

  chk_up_wrap_zero:
    assert property (fast_run && plain_kind && !I_COUNT_DOWN && !I_TOP_WR
      && O_COUNT_VALUE == O_TOP_VALUE |=> O_COUNT_VALUE == 16'h0000)
    else $error("count did not clear after top");
  chk_down_reload:
    assert property (fast_run && plain_kind && I_COUNT_DOWN && !I_TOP_WR
      && !O_TOP_SHADOW_VALID && O_COUNT_VALUE == 16'h0000
      |=> O_COUNT_VALUE == $past(O_TOP_VALUE))
    else $error("count not reloaded from top");
  chk_down_step:
    assert property (fast_run && I_WAVEFORM_KIND == btw_pkg::KIND_NORMAL
      && I_COUNT_DOWN && O_COUNT_VALUE != 16'h0000
      |=> O_COUNT_VALUE == $past(O_COUNT_VALUE) - 16'h0001)
    else $error("count did not step down");
  chk_count_write:
    assert property (I_COUNT_WR |=> O_COUNT_VALUE == $past(I_COUNT_WDATA))
    else $error("count write lost");
  chk_stopped_hold:
    assert property (!I_RUN_ENABLE && !I_COUNT_WR |=> $stable(O_COUNT_VALUE))
    else $error("count moved while stopped");
  chk_event_idle:
    assert property (I_EVENT_COUNT_ON && !I_EVENT_IN && !I_COUNT_WR
      |=> $stable(O_COUNT_VALUE))
    else $error("count moved without event");
  chk_shadow_valid:
    assert property (I_TOP_SHADOW_WR |=> O_TOP_SHADOW_VALID)
    else $error("top shadow valid not set");
  chk_valid_on_update:
    assert property ($fell(O_TOP_SHADOW_VALID) |-> O_UPDATE)
    else $error("top shadow consumed outside update");
  chk_top_change_cause:
    assert property ($changed(O_TOP_VALUE) |-> $past(I_TOP_WR) || O_UPDATE)
    else $error("top changed without write or update");
  chk_pin_override:
    assert property (1'b1 |=> O_WAVE_PIN_OUT == $past(pin_exp))
    else $error("pin value wrong source");
endmodule : btw_timer_properties

bind btw_timer btw_timer_properties #(.N_CH(N_CH)) btw_timer_properties_inst (
  .I_MCLK, .I_SYS_RST, .I_RUN_ENABLE, .I_PRESCALE_CHOICE, .I_COUNT_DOWN,
  .I_EVENT_COUNT_ON, .I_EVENT_IN, .I_WAVEFORM_KIND, .I_MATCH_OUTPUT_ON,
  .I_PIN_OUT, .I_COUNT_WR, .I_COUNT_WDATA, .I_TOP_WR, .I_TOP_SHADOW_WR,
  .O_COUNT_VALUE, .O_TOP_VALUE, .O_TOP_SHADOW_VALID, .O_UPDATE,
  .O_WAVE_SIGNAL, .O_WAVE_PIN_OUT);

`default_nettype wire

// *** tb/btw_port_model.sv ***
// Far-side model: event source and ordinary pin values
`timescale 1ns/10ps
`default_nettype none

module btw_port_model (
  input  wire logic i_clk,
  input  wire logic i_fire,
  output logic      o_event,
  output logic [2:0] o_pins
);
  logic [3:0] left_q = 4'h0;
  logic       fire_now;

  // A slow source: three single-cycle events with idle gaps between them;
  // one process owns both outputs so each has a single driver
  initial begin
    o_event = 1'b0;
    o_pins = 3'h5;
    forever begin
      @(posedge i_clk);
      fire_now = i_fire;
      #1;
      o_pins = o_pins + 3'h1;
      if (fire_now) begin
        left_q = 4'h6;
      end else if (left_q != 4'h0) begin
        left_q = left_q - 4'h1;
      end
      o_event = left_q[0];
    end
  end
endmodule : btw_port_model

`default_nettype wire

// *** tb/btw_timer_tb_top.sv ***
// Self-checking testbench for the buffered timer waveform core
`timescale 1ns/10ps
`default_nettype none

module btw_timer_tb_top;
  localparam int DIVS [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b0, cdown = 1'b0, ev_on = 1'b0, fire = 1'b0;
  logic        cwr = 1'b0, twr = 1'b0, tswr = 1'b0, tsv, upd, ev, ddown;
  logic [2:0]  choice = 3'h0, on = 3'h0, mwr = 3'h0, mswr = 3'h0;
  logic [2:0]  fclr = 3'h0, msv, flag, wave, pin, pins;
  logic [1:0]  kind = 2'h0;
  logic [15:0] cwd = 16'h0000, twd = 16'h0000, tswd = 16'h0000;
  logic [15:0] mwd = 16'h0000, mswd = 16'h0000, cnt, top;
  int          miscompares = 0;
  int          samples_checked = 0;

  btw_timer #(.N_CH(3)) btw_timer_inst (
    .I_MCLK(clk), .I_SYS_RST(rst), .I_RUN_ENABLE(run),
    .I_PRESCALE_CHOICE(choice), .I_COUNT_DOWN(cdown),
    .I_EVENT_COUNT_ON(ev_on), .I_EVENT_IN(ev), .I_WAVEFORM_KIND(kind),
    .I_MATCH_OUTPUT_ON(on), .I_PIN_OUT(pins), .I_COUNT_WR(cwr),
    .I_COUNT_WDATA(cwd), .I_TOP_WR(twr), .I_TOP_WDATA(twd),
    .I_TOP_SHADOW_WR(tswr), .I_TOP_SHADOW_WDATA(tswd), .I_MATCH_WR(mwr),
    .I_MATCH_WDATA(mwd), .I_MATCH_SHADOW_WR(mswr),
    .I_MATCH_SHADOW_WDATA(mswd), .I_MATCH_FLAG_CLR(fclr),
    .O_COUNT_VALUE(cnt), .O_TOP_VALUE(top), .O_TOP_SHADOW_VALID(tsv),
    .O_MATCH_SHADOW_VALID(msv), .O_MATCH_FLAG(flag), .O_UPDATE(upd),
    .O_DUAL_DOWN(ddown), .O_WAVE_SIGNAL(wave), .O_WAVE_PIN_OUT(pin));

  btw_port_model btw_port_model_inst (
    .i_clk(clk), .i_fire(fire), .o_event(ev), .o_pins(pins));

  initial forever #50 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One edge for all strobes, then they drop together
  task automatic pulse;
    step(1);
    cwr = 1'b0;
    twr = 1'b0;
    tswr = 1'b0;
    mwr = 3'h0;
    mswr = 3'h0;
    fclr = 3'h0;
  endtask : pulse

  task automatic wait_cnt(input logic [15:0] v);
    for (int i = 0; i < 50 && cnt !== v; i++) step(1);
    chk("count reached", v, cnt);
  endtask : wait_cnt

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_single;
    kind = 2'h3;
    on = 3'h1;
    twr = 1'b1;
    twd = 16'h0003;
    mwr = 3'h1;
    mwd = 16'h0001;
    cwr = 1'b1;
    fclr = 3'h7;
    pulse;
    run = 1'b1;
    wait_cnt(16'h0003);
    step(3);
    chk("count", 16'h0002, cnt);
    chk("wave", 16'h0000, {15'h0000, wave[0]});
    chk("pin", 16'h0001, {15'h0000, pin[0]});
    chk("flag", 16'h0001, {15'h0000, flag[0]});
    run = 1'b0;
    fclr = 3'h1;
    pulse;
    chk("flag cleared", 16'h0000, {15'h0000, flag[0]});
    $display("test single slope done");
  endtask : t_single

  task automatic t_down;
    kind = 2'h0;
    cdown = 1'b1;
    run = 1'b1;
    cwr = 1'b1;
    cwd = 16'h0002;
    pulse;
    chk("count written", 16'h0002, cnt);
    step(2);
    chk("bottom", 16'h0000, cnt);
    step(1);
    chk("reload", 16'h0003, cnt);
    cdown = 1'b0;
    step(1);
    chk("turned up", 16'h0000, cnt);
    $display("test down count done");
  endtask : t_down

  task automatic t_shadow;
    tswr = 1'b1;
    tswd = 16'h0005;
    mswr = 3'h2;
    mswd = 16'h0002;
    pulse;
    chk("top valid", 16'h0001, {15'h0000, tsv});
    chk("top kept", 16'h0003, top);
    chk("match valid", 16'h0002, {13'h0000, msv});
    for (int i = 0; i < 20 && upd !== 1'b1; i++) step(1);
    chk("top copied", 16'h0005, top);
    chk("valids", 16'h0000, {12'h000, tsv, msv});
    cwr = 1'b1;
    cwd = 16'hFFFD;
    twr = 1'b1;
    twd = 16'h0002;
    pulse;
    chk("top direct", 16'h0002, top);
    step(2);
    chk("count max", 16'hffff, cnt);
    step(1);
    chk("count wrapped", 16'h0000, cnt);
    $display("test buffering done");
  endtask : t_shadow

  task automatic t_freq;
    logic w;
    kind = 2'h1;
    mwr = 3'h1;
    mwd = 16'h0000;
    cwr = 1'b1;
    cwd = 16'h0000;
    pulse;
    step(1);
    w = wave[0];
    step(1);
    chk("toggle", {15'h0000, ~w}, {15'h0000, wave[0]});
    step(1);
    chk("toggle back", {15'h0000, w}, {15'h0000, wave[0]});
    chk("count", 16'h0000, cnt);
    $display("test frequency done");
  endtask : t_freq

  // Top 3, match 2 direct, match shadow 1: counts 0,1,2,3,2,1,0,1
  task automatic t_dual;
    run = 1'b0;
    kind = 2'h2;
    on = 3'h1;
    twr = 1'b1;
    twd = 16'h0003;
    mwr = 3'h1;
    mwd = 16'h0002;
    mswr = 3'h1;
    mswd = 16'h0001;
    cwr = 1'b1;
    cwd = 16'h0000;
    pulse;
    run = 1'b1;
    step(4);
    chk("dual top turn", 16'h0002, cnt);
    chk("dual down", 16'h0001, {15'h0000, ddown});
    chk("dual rising match", 16'h0000, {15'h0000, wave[0]});
    chk("no update at top", 16'h0001, {13'h0000, msv});
    step(1);
    chk("dual falling match", 16'h0001, {15'h0000, wave[0]});
    step(2);
    chk("dual bottom", 16'h0001, cnt);
    chk("dual up", 16'h0000, {15'h0000, ddown});
    chk("update at bottom", 16'h0001, {15'h0000, upd});
    chk("match copied", 16'h0000, {13'h0000, msv});
    chk("dual pin", 16'h0001, {15'h0000, pin[0]});
    step(1);
    chk("new match used", 16'h0000, {15'h0000, wave[0]});
    $display("test dual slope done");
  endtask : t_dual

  task automatic t_prescale;
    kind = 2'h0;
    twr = 1'b1;
    twd = 16'hffff;
    for (int k = 0; k < 8; k++) begin
      run = 1'b0;
      choice = k[2:0];
      cwr = 1'b1;
      cwd = 16'h0000;
      pulse;
      run = 1'b1;
      step(2 * DIVS[k]);
      chk("prescaled count", 16'h0002, cnt);
    end
    $display("test prescaler done");
  endtask : t_prescale

  task automatic t_event;
    run = 1'b0;
    kind = 2'h3;
    on = 3'h7;
    ev_on = 1'b1;
    cwr = 1'b1;
    cwd = 16'h0000;
    pulse;
    run = 1'b1;
    fire = 1'b1;
    step(1);
    fire = 1'b0;
    step(10);
    chk("event count", 16'h0003, cnt);
    $display("test event count done");
  endtask : t_event

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_single;
    t_down;
    t_shadow;
    t_freq;
    t_dual;
    t_prescale;
    t_event;
    tally_and_finish;
  end

  // Whole run is about 3000 cycles; twice that means a hang
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
endmodule : btw_timer_tb_top

`default_nettype wire
